// ==== src/sdf_consts.svh ====
/*
 Constants of the sigma-delta decimation filter: register offsets, field
 positions, reset values and settling counts.
 Assumes inclusion by the filter module; definitions only.
*/
`ifndef SDF_CONSTS_SVH
`define SDF_CONSTS_SVH

// register byte offsets on the APB port
`define SDF_OFF_CTRL      12'h000
`define SDF_OFF_STATUS    12'h004
`define SDF_OFF_DATA      12'h008
`define SDF_OFF_SETTLE    12'h00C

// control field positions
`define SDF_CTRL_DIV_LSB  0
`define SDF_CTRL_DRS_LSB  2
`define SDF_CTRL_HR_BIT   5
`define SDF_CTRL_EN_BIT   6
`define SDF_CTRL_RSY_BIT  7

// reset values
`define SDF_CTRL_RST      7'h0C
`define SDF_SAMPLE_RST    32'h0000_0000

// ratio exponents: high-rate ratio, base ratio, largest single sinc3 stage; fast-path conversion count
`define SDF_HR_LG         4'h6
`define SDF_BASE_LG       4'h7
`define SDF_S3_LG_MAX     4'hA
`define SDF_FAST_CONVS    2'h2

// settling counts in main-clock periods
`define SDF_SETTLE_TAIL   16'h0030
`define SDF_STAGE_FIXED   16'h0400
`define SDF_SETTLE_CAP    16'h8830

`endif

// ==== src/sdf_pkg.sv ====
/*
 Types shared by the decimation filter modules.
 Assumes sdf_consts.svh is on the include path.
*/
package sdf_pkg;

   // settle tracking, gray coded along standby -> settling -> settled
   typedef enum logic [1:0] {
      st_standby  = 2'b00,
      st_settling = 2'b01,
      st_settled  = 2'b11
   } sdf_state_t;

   // software configuration carried as one word
   typedef struct packed {
      logic       enable;
      logic       high_rate;
      logic [2:0] decimation_ratio_select;
      logic [1:0] div_sel;
   } sdf_cfg_t;

endpackage : sdf_pkg

// ==== src/sdf_sinc3_core.sv ====
/*
 Third-order sinc (CIC) core: three integrators on each modulator tick and
 three combs on each dump request.
 Assumes dump_i only coincides with tick_i and at most 1024 ticks per dump.
*/
`timescale 1ns/100ps

module sdf_sinc3_core
   import sdf_pkg::*;
(
   input  wire logic        clock_i,   // main clock
   input  wire logic        reset_n_i, // async reset, active low
   input  wire logic        clear_i,   // restart, empties the filter
   input  wire logic        tick_i,    // modulator tick
   input  wire logic        bit_i,     // modulator bit
   input  wire logic        dump_i,    // decimate at this tick
   output logic [30:0]      result_o,  // sinc3 word, full scale 2^(3*lg)
   output logic             valid_o    // one-cycle result strobe
);

   logic [30:0] i1_reg, i2_reg, i3_reg, d1_reg, d2_reg, d3_reg;
   logic [30:0] i1_next, i2_next, i3_next, d1_next, d2_next, d3_next;
   logic [30:0] res_reg, res_next, c1, c2;
   logic        val_reg, val_next;

   // integrators wrap on purpose; the combs undo the wrap exactly
   always_comb begin
      {i1_next, i2_next, i3_next} = {i1_reg, i2_reg, i3_reg};
      {d1_next, d2_next, d3_next} = {d1_reg, d2_reg, d3_reg};
      res_next = res_reg;
      val_next = 1'b0;
      c1 = 31'h0;
      c2 = 31'h0;
      if (clear_i) begin
         {i1_next, i2_next, i3_next} = 93'h0;
         {d1_next, d2_next, d3_next} = 93'h0;
      end else if (tick_i) begin
         i1_next = i1_reg + {30'h0, bit_i};
         i2_next = i2_reg + i1_next;
         i3_next = i3_reg + i2_next;
         if (dump_i) begin
            c1       = i3_next - d1_reg;
            c2       = c1 - d2_reg;
            res_next = c2 - d3_reg;
            d1_next  = i3_next;
            d2_next  = c1;
            d3_next  = c2;
            val_next = 1'b1;
         end
      end
   end

   // state registers
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         {i1_reg, i2_reg, i3_reg} <= 93'h0;
         {d1_reg, d2_reg, d3_reg} <= 93'h0;
         res_reg <= 31'h0;
         val_reg <= 1'b0;
      end else begin
         {i1_reg, i2_reg, i3_reg} <= {i1_next, i2_next, i3_next};
         {d1_reg, d2_reg, d3_reg} <= {d1_next, d2_next, d3_next};
         res_reg <= res_next;
         val_reg <= val_next;
      end
   end

   assign result_o = res_reg;
   assign valid_o  = val_reg;

endmodule : sdf_sinc3_core

// ==== src/sdf_filter.sv ====
/*
 Decimation filter for one delta-sigma channel, with APB registers.
 Assumes the modulator bit and resync arrive from outside this clock domain,
 and the gain/mux change strobe comes from logic on clock_i.
*/
// The address map and the APB interface to the registers were left to the implementer.
// What this block does
// - modulator tick comes from main clock by divider; one bit per tick
// - divider select 00/01/10/11 gives 2/4/8/12, default divide by 2
// - ratio select picks 128 to 16384 in binary steps
// - high-rate bit forces ratio 64 instead
// - output rate is modulator rate over the ratio
// - bitstream feeds sinc3 path and fast sinc1 path in parallel
// - after reset, outputs come from the fast sinc1 path
// - after two conversions, switch to sinc3 path until reset
// - ratios 64 to 1024 use sinc3 directly at full ratio
// - ratios 2048 up: sinc3 at 1024 then sinc1 by 2 to 16
// - nulls at multiples of output rate, from sinc averaging
// - enable, gain/mux change or resync restarts settling
// - unsettled samples are delivered, never suppressed
// - single-stage settling is 3 x ratio + 48 main clocks
// - cascaded settling is (2 x stage2 + 2) x 1024 + 48 clocks
`timescale 1ns/100ps
`include "sdf_consts.svh"

module sdf_filter
   import sdf_pkg::*;
#(
   parameter logic [15:0] SETTLE_CAP = `SDF_SETTLE_CAP // caps settling count
)(
   input  wire logic        clock_i,            // main clock input, 10 MHz
   input  wire logic        reset_n_i,          // async reset, active low
   input  wire logic        psel_i,             // APB select
   input  wire logic        penable_i,          // APB enable
   input  wire logic        pwrite_i,           // APB write
   input  wire logic [11:0] paddr_i,            // APB byte address
   input  wire logic [31:0] pwdata_i,           // APB write data
   output logic [31:0]      prdata_o,           // APB read data
   output logic             pready_o,           // APB ready
   output logic             pslverr_o,          // APB error, unmapped
   input  wire logic        mod_bit_i,          // modulator bitstream pin
   input  wire logic        resync_i,           // resync pin, rising edge
   input  wire logic        gain_mux_change_i,  // gain or mux changed pulse
   output logic [31:0]      sample_o,           // signed output word
   output logic             sample_valid_o,     // one-cycle sample strobe
   output logic             modulator_tick_o,   // modulator tick pulse
   output logic             sinc3_active_o,     // sinc3 path selected
   output logic             settled_o           // settling time elapsed
);

   function automatic logic [3:0] sdf_div_ratio(input logic [1:0] s);
      case (s)
         2'h0:    return 4'h2;
         2'h1:    return 4'h4;
         2'h2:    return 4'h8;
         default: return 4'hC;
      endcase
   endfunction : sdf_div_ratio

   function automatic logic [15:0] sdf_settle(input logic [3:0] lg);
      if (lg <= `SDF_S3_LG_MAX)
         return 16'h3 * (16'h1 << lg) + `SDF_SETTLE_TAIL;
      return ((16'h2 << (lg - `SDF_S3_LG_MAX)) + 16'h2) * `SDF_STAGE_FIXED
             + `SDF_SETTLE_TAIL;
   endfunction : sdf_settle

   // unipolar count of full scale 2^b to a signed 32-bit word
   function automatic logic [31:0] sdf_norm(input logic [35:0] v, input logic [5:0] b);
      logic [67:0] t;
      t = {32'h0, v};
      if (b <= 6'h1F) t = t << (6'h1F - b);
      else            t = t >> (b - 6'h1F);
      if (t >= 68'h0_8000_0000) return 32'h7FFF_FFFF;
      return t[31:0] - 32'h8000_0000;
   endfunction : sdf_norm

   sdf_cfg_t    ctrl_reg, ctrl_next;
   sdf_state_t  state_reg, state_next;
   logic [2:0]  bit_sy_reg, bit_sy_next, rsy_sy_reg, rsy_sy_next;
   logic        bit_reg, bit_next, rsy_reg, rsy_next, sw_rsy_reg, sw_rsy_next;
   logic [3:0]  div_cnt_reg, div_cnt_next;
   logic        tick_reg, tick_next;
   logic [13:0] phase_reg, phase_next, osr_m1, s3_mask;
   logic [14:0] fast_acc_reg, fast_acc_next, fast_hold_reg, fast_hold_next;
   logic [35:0] s1_acc_reg, s1_acc_next, acc_sum;
   logic        final_d_reg, final_d_next;
   logic [1:0]  conv_cnt_reg, conv_cnt_next;
   logic [15:0] settle_cnt_reg, settle_cnt_next, settle_load;
   logic [31:0] sample_reg, sample_next, prdata_reg, prdata_next, rd_word;
   logic        valid_reg, valid_next, sinc3_reg, sinc3_next, settled_reg, settled_next;
   logic        pready_reg, pready_next, pslverr_reg, pslverr_next;
   logic        restart, running, s3_dump, final_tick, s3_valid, en_prev_reg;
   logic        wr_go, rd_hit;
   logic [3:0]  lg, s3lg;
   logic [30:0] s3_result;

   // ratio exponent; high-rate bit overrides the ratio select
   assign lg   = ctrl_reg.high_rate ? `SDF_HR_LG
               : `SDF_BASE_LG + {1'b0, ctrl_reg.decimation_ratio_select};
   assign s3lg = (lg > `SDF_S3_LG_MAX) ? `SDF_S3_LG_MAX : lg;
   assign osr_m1  = 14'((15'h1 << lg) - 15'h1);
   assign s3_mask = 14'((15'h1 << s3lg) - 15'h1);
   assign settle_load = (sdf_settle(lg) > SETTLE_CAP) ? SETTLE_CAP : sdf_settle(lg);

   // restart events; ratio is trusted stable while running
   assign running    = (state_reg != st_standby);
   assign restart    = ctrl_reg.enable & (~en_prev_reg | sw_rsy_reg
                     | gain_mux_change_i | (rsy_next & ~rsy_reg));
   assign final_tick = running & tick_reg & (phase_reg == osr_m1);
   assign s3_dump    = running & tick_reg & ((phase_reg & s3_mask) == s3_mask);
   assign acc_sum    = s1_acc_reg + {5'h0, s3_result};

   // sinc3 path, runs beside the fast path on the same bits
   sdf_sinc3_core u_sinc3 (
      .clock_i   (clock_i),
      .reset_n_i (reset_n_i),
      .clear_i   (restart | ~running),
      .tick_i    (running & tick_reg),
      .bit_i     (bit_reg),
      .dump_i    (s3_dump),
      .result_o  (s3_result),
      .valid_o   (s3_valid)
   );

   // three-stage pin synchronisers; accept a change once stages 2 and 3 agree
   always_comb begin
      bit_sy_next = {bit_sy_reg[1:0], mod_bit_i};
      rsy_sy_next = {rsy_sy_reg[1:0], resync_i};
      bit_next    = (bit_sy_reg[1] == bit_sy_reg[2]) ? bit_sy_reg[2] : bit_reg;
      rsy_next    = (rsy_sy_reg[1] == rsy_sy_reg[2]) ? rsy_sy_reg[2] : rsy_reg;
   end

   // modulator tick divider, free running
   always_comb begin
      tick_next    = 1'b0;
      div_cnt_next = div_cnt_reg + 4'h1;
      if (div_cnt_reg >= sdf_div_ratio(ctrl_reg.div_sel) - 4'h1) begin
         div_cnt_next = 4'h0;
         tick_next    = 1'b1;
      end
   end

   // phase, fast sinc1 path, second sinc1 stage and output select
   always_comb begin
      phase_next     = phase_reg;
      fast_acc_next  = fast_acc_reg;
      fast_hold_next = fast_hold_reg;
      s1_acc_next    = s1_acc_reg;
      final_d_next   = final_tick;
      conv_cnt_next  = conv_cnt_reg;
      sample_next    = sample_reg;
      valid_next     = 1'b0;
      if (restart || !running) begin
         phase_next    = 14'h0;
         fast_acc_next = 15'h0;
         s1_acc_next   = 36'h0;
         final_d_next  = 1'b0;
      end else begin
         if (tick_reg) begin
            phase_next    = final_tick ? 14'h0 : phase_reg + 14'h1;
            fast_acc_next = final_tick ? 15'h0 : fast_acc_reg + {14'h0, bit_reg};
            if (final_tick)
               fast_hold_next = fast_acc_reg + {14'h0, bit_reg};
         end
         if (s3_valid)
            s1_acc_next = final_d_reg ? 36'h0 : acc_sum;
         if (final_d_reg) begin
            valid_next = 1'b1;
            if (conv_cnt_reg < `SDF_FAST_CONVS) begin
               sample_next   = sdf_norm({21'h0, fast_hold_reg}, {2'h0, lg});
               conv_cnt_next = conv_cnt_reg + 2'h1;
            end else
               sample_next = sdf_norm(acc_sum, 6'(3 * s3lg + (lg - s3lg)));
         end
      end
      sinc3_next = (conv_cnt_next == `SDF_FAST_CONVS);
   end

   // settle tracking; load on restart, never gates data
   always_comb begin
      state_next      = state_reg;
      settle_cnt_next = settle_cnt_reg;
      if (!ctrl_reg.enable) begin
         state_next      = st_standby;
         settle_cnt_next = 16'h0;
      end else if (restart) begin
         state_next      = st_settling;
         settle_cnt_next = settle_load;
      end else if (state_reg == st_settling) begin
         if (settle_cnt_reg <= 16'h1) begin
            state_next      = st_settled;
            settle_cnt_next = 16'h0;
         end else
            settle_cnt_next = settle_cnt_reg - 16'h1;
      end
      settled_next = (state_next == st_settled);
   end

   // APB slave: one wait state, write lands on the ready edge
   always_comb begin
      pready_next  = psel_i & penable_i & ~pready_reg;
      wr_go        = psel_i & penable_i & pready_reg & pwrite_i;
      rd_hit       = 1'b1;
      rd_word      = 32'h0;
      ctrl_next    = ctrl_reg;
      sw_rsy_next  = 1'b0;
      if (paddr_i == `SDF_OFF_CTRL)
         rd_word = {25'h0, ctrl_reg};
      else if (paddr_i == `SDF_OFF_STATUS)
         rd_word = {26'h0, state_reg, conv_cnt_reg, sinc3_reg, settled_reg};
      else if (paddr_i == `SDF_OFF_DATA)
         rd_word = sample_reg;
      else if (paddr_i == `SDF_OFF_SETTLE)
         rd_word = {16'h0, settle_cnt_reg};
      else
         rd_hit = 1'b0;
      if (wr_go && paddr_i == `SDF_OFF_CTRL) begin
         ctrl_next   = sdf_cfg_t'(pwdata_i[`SDF_CTRL_EN_BIT:`SDF_CTRL_DIV_LSB]);
         sw_rsy_next = pwdata_i[`SDF_CTRL_RSY_BIT];
      end
      prdata_next  = (pready_next && !pwrite_i) ? rd_word : prdata_reg;
      pslverr_next = pready_next & ~rd_hit;
   end

   // all state registers except the assertion helpers below
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_reg       <= sdf_cfg_t'(`SDF_CTRL_RST);
         state_reg      <= st_standby;
         {bit_sy_reg, rsy_sy_reg} <= 6'h0;
         {bit_reg, rsy_reg, sw_rsy_reg, en_prev_reg} <= 4'h0;
         div_cnt_reg    <= 4'h0;
         tick_reg       <= 1'b0;
         phase_reg      <= 14'h0;
         fast_acc_reg   <= 15'h0;
         fast_hold_reg  <= 15'h0;
         s1_acc_reg     <= 36'h0;
         final_d_reg    <= 1'b0;
         conv_cnt_reg   <= 2'h0;
         settle_cnt_reg <= 16'h0;
         sample_reg     <= `SDF_SAMPLE_RST;
         {valid_reg, sinc3_reg, settled_reg} <= 3'h0;
         prdata_reg     <= 32'h0;
         {pready_reg, pslverr_reg} <= 2'h0;
      end else begin
         ctrl_reg       <= ctrl_next;
         state_reg      <= state_next;
         {bit_sy_reg, rsy_sy_reg} <= {bit_sy_next, rsy_sy_next};
         {bit_reg, rsy_reg, sw_rsy_reg, en_prev_reg} <=
            {bit_next, rsy_next, sw_rsy_next, ctrl_reg.enable};
         div_cnt_reg    <= div_cnt_next;
         tick_reg       <= tick_next;
         phase_reg      <= phase_next;
         fast_acc_reg   <= fast_acc_next;
         fast_hold_reg  <= fast_hold_next;
         s1_acc_reg     <= s1_acc_next;
         final_d_reg    <= final_d_next;
         conv_cnt_reg   <= conv_cnt_next;
         settle_cnt_reg <= settle_cnt_next;
         sample_reg     <= sample_next;
         {valid_reg, sinc3_reg, settled_reg} <= {valid_next, sinc3_next, settled_next};
         prdata_reg     <= prdata_next;
         {pready_reg, pslverr_reg} <= {pready_next, pslverr_next};
      end
   end

   assign prdata_o         = prdata_reg;
   assign pready_o         = pready_reg;
   assign pslverr_o        = pslverr_reg;
   assign sample_o         = sample_reg;
   assign sample_valid_o   = valid_reg;
   assign modulator_tick_o = tick_reg;
   assign sinc3_active_o   = sinc3_reg;
   assign settled_o        = settled_reg;

   // helpers: clocks between ticks, ticks between samples
   logic [3:0]  gap_reg;
   logic        gap_ok_reg, tk_ok_reg;
   logic [14:0] tk_reg;
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         gap_reg    <= 4'h0;
         gap_ok_reg <= 1'b0;
         tk_reg     <= 15'h0;
         tk_ok_reg  <= 1'b0;
      end else begin
         gap_reg    <= tick_reg ? 4'h0 : gap_reg + 4'h1;
         gap_ok_reg <= (ctrl_next.div_sel != ctrl_reg.div_sel) ? 1'b0
                     : (tick_reg ? 1'b1 : gap_ok_reg);
         tk_reg     <= valid_reg ? {14'h0, tick_reg} : tk_reg + {14'h0, tick_reg};
         tk_ok_reg  <= (restart || !running) ? 1'b0 : (valid_reg ? 1'b1 : tk_ok_reg);
      end
   end

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);

   AST_TICK_GAP: assert property (tick_reg && gap_ok_reg && $stable(ctrl_reg.div_sel)
      |-> gap_reg == sdf_div_ratio(ctrl_reg.div_sel) - 4'h1)
      else $error("modulator tick spacing wrong");
   AST_SAMPLE_SPACING: assert property (valid_reg && tk_ok_reg && !restart
      |-> tk_reg == 15'(15'h1 << lg))
      else $error("sample spacing differs from ratio");
   AST_VALID_PULSE: assert property (valid_reg |=> !valid_reg)
      else $error("sample strobe longer than one cycle");
   AST_FAST_FIRST: assert property (valid_reg && !sinc3_reg |-> $past(conv_cnt_reg) < 2'h2)
      else $error("fast path used past two conversions");
   AST_SINC3_STAYS: assert property (sinc3_reg |=> sinc3_reg)
      else $error("sinc3 path left before reset");
   AST_NO_GATING: assert property (final_d_reg && running && !restart |=> valid_reg)
      else $error("output suppressed");
   AST_SETTLE_LOAD: assert property (restart |=> settle_cnt_reg == settle_load
      && state_reg == st_settling)
      else $error("settling not restarted");
   AST_SETTLE_64: assert property (restart && lg == `SDF_HR_LG && SETTLE_CAP >= 16'hF0
      |=> settle_cnt_reg == 16'hF0)
      else $error("settling count at ratio 64 wrong");
   AST_CASCADE: assert property (running && tick_reg && !restart && lg > `SDF_S3_LG_MAX
      && phase_reg[9:0] == 10'h3FF |-> s3_dump)
      else $error("sinc3 stage not dumping every 1024 ticks");
   AST_APB_READY: assert property (psel_i && penable_i && !pready_reg |=> pready_reg)
      else $error("APB answer late");

   COV_SWITCH: cover property (!sinc3_reg ##1 sinc3_reg);
   COV_SETTLED: cover property ($rose(settled_reg));
   COV_CASCADE_OUT: cover property (valid_reg && lg > `SDF_S3_LG_MAX);

endmodule : sdf_filter

// ==== tb/sdf_host_model.sv ====
/*
 Host-side model: watches the filter's sample strobe and keeps only samples
 taken after settling plus one further conversion.
 Assumes the strobe and settle flag of sdf_filter on the same clock.
*/
`timescale 1ns/100ps

module sdf_host_model (
   input  wire logic        clock_i,   // main clock
   input  wire logic        reset_n_i, // async reset, active low
   input  wire logic [31:0] sample_i,  // filter output word
   input  wire logic        valid_i,   // one-cycle sample strobe
   input  wire logic        settled_i, // settle flag of the filter
   output logic [31:0]      good_o,    // last trusted sample
   output logic [7:0]       n_good_o   // trusted samples so far
);
   logic seen_reg; // first settled conversion already dropped

   // unsettled data is never flagged, so the host must drop it itself
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         seen_reg <= 1'b0;
         good_o   <= 32'h0000_0000;
         n_good_o <= 8'h00;
      end else if (!settled_i) begin
         seen_reg <= 1'b0;
      end else if (valid_i) begin
         if (seen_reg) begin
            good_o   <= sample_i;
            n_good_o <= n_good_o + 8'h01;
         end
         seen_reg <= 1'b1;
      end
   end
endmodule : sdf_host_model

// ==== tb/testbench.sv ====
/*
 Self-checking bench for sdf_filter: APB master, modulator bit source,
 host model on the sample stream.
 Assumes sdf_pkg and sdf_consts.svh are compiled first.
*/
`timescale 1ns/100ps

module testbench;
   logic        clock_i = 1'b0;
   logic        reset_n_i = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic        mod_bit = 1'b1, resync = 1'b0, gmc = 1'b0;
   logic [31:0] prdata, sample, good, q;
   logic        pready, pslverr, svalid, tick, s3act, settled, err;
   logic [7:0]  n_good;
   int          cyc = 0, n_mismatch = 0, checked = 0, t0, t1, te;

   sdf_filter u_dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .mod_bit_i(mod_bit), .resync_i(resync), .gain_mux_change_i(gmc),
      .sample_o(sample), .sample_valid_o(svalid), .modulator_tick_o(tick),
      .sinc3_active_o(s3act), .settled_o(settled));
   sdf_host_model u_host (.clock_i(clock_i), .reset_n_i(reset_n_i),
      .sample_i(sample), .valid_i(svalid), .settled_i(settled), .good_o(good),
      .n_good_o(n_good));

   always #50 clock_i = ~clock_i;

   // cycle count doubles as the hang guard
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc >= 60000) begin
         n_mismatch++;
         end_sim();
      end
   end

   task automatic chk(input logic ok, input string m);
      checked++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("MISMATCH t=%0t %s", $time, m);
      end
   endtask : chk

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim

   // one APB transfer; held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      do @(posedge clock_i); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   function automatic logic [31:0] ctrl(input logic [1:0] dv, input logic [2:0] dr,
                                        input logic hr, input logic en);
      return {24'h00_0000, 1'b0, en, hr, dr, dv};
   endfunction : ctrl

   // next sample: time and word, then the strobe must be gone
   task automatic wait_sv;
      do @(posedge clock_i); while (svalid !== 1'b1);
      t1 = cyc;
      q = sample;
      @(posedge clock_i);
      chk(svalid === 1'b0, "strobe longer than one cycle");
   endtask : wait_sv

   task automatic t_reset;
      apb(1'b0, 12'h000, 32'h0);
      chk(q === 32'h0000_000C, "ctrl reset value");
      apb(1'b0, 12'h004, 32'h0);
      chk(q[5:0] === 6'h00, "status reset value");
      apb(1'b1, 12'h010, 32'hFFFF_FFFF);
      chk(err === 1'b1, "unmapped write not refused");
      apb(1'b0, 12'h010, 32'h0);
      chk(err === 1'b1 && q === 32'h0, "unmapped read");
      apb(1'b0, 12'h000, 32'h0);
      chk(q === 32'h0000_000C && s3act === 1'b0, "ctrl after unmapped write");
      $display("test reset done");
   endtask : t_reset

   // tick spacing for every divider code, in standby
   task automatic t_div;
      int per[4] = '{2, 4, 8, 12};
      for (int d = 0; d < 4; d++) begin
         apb(1'b1, 12'h000, ctrl(d[1:0], 3'h3, 1'b0, 1'b0));
         repeat (2) do @(posedge clock_i); while (tick !== 1'b1);
         t0 = cyc;
         do @(posedge clock_i); while (tick !== 1'b1);
         chk(cyc - t0 === per[d], "tick spacing");
      end
      $display("test divider done");
   endtask : t_div

   // fast path first, then sinc3; ratio 64 at divide by 2
   task automatic t_fast;
      apb(1'b1, 12'h000, ctrl(2'h0, 3'h0, 1'b1, 1'b1));
      apb(1'b0, 12'h00C, 32'h0);
      chk(q <= 32'd240 && q >= 32'd228, "settle count at ratio 64");
      wait_sv();
      chk(q === 32'h7FFF_FFFF && s3act === 1'b0, "first fast sample");
      chk(settled === 1'b0, "settled too early");
      wait_sv();
      t0 = t1;
      wait_sv();
      chk(t1 - t0 === 128, "sample period at ratio 64");
      chk(s3act === 1'b1 && settled === 1'b1, "sinc3 after two");
      $display("test fast path done");
   endtask : t_fast

   // restarts keep sinc3 and keep delivering samples
   task automatic t_restart;
      mod_bit <= 1'b0;
      @(posedge clock_i);
      gmc <= 1'b1;
      @(posedge clock_i);
      gmc <= 1'b0;
      repeat (3) @(posedge clock_i);
      chk(settled === 1'b0, "gain change no restart");
      wait_sv();
      chk(settled === 1'b0 && s3act === 1'b1, "unsettled sample");
      repeat (4) wait_sv();
      chk(good === 32'h8000_0000 && n_good !== 8'h00, "settled zero word");
      resync <= 1'b1;
      repeat (4) @(posedge clock_i);
      resync <= 1'b0;
      repeat (6) @(posedge clock_i);
      chk(settled === 1'b0, "resync no restart");
      repeat (3) wait_sv();
      apb(1'b0, 12'h008, 32'h0);
      chk(q === 32'h8000_0000 && settled === 1'b1, "data register word");
      apb(1'b1, 12'h000, ctrl(2'h0, 3'h0, 1'b1, 1'b1) | 32'h0000_0080);
      repeat (2) @(posedge clock_i);
      chk(settled === 1'b0, "software resync no restart");
      $display("test restart done");
   endtask : t_restart

   // sample period and settle count for ratios 128 to 2048
   task automatic t_rates;
      int ex;
      for (int c = 0; c < 5; c++) begin
         ex = (c < 4) ? 3 * (128 << c) + 48 : (2 * 2 + 2) * 1024 + 48;
         apb(1'b1, 12'h000, ctrl(2'h0, c[2:0], 1'b0, 1'b0));
         apb(1'b1, 12'h000, ctrl(2'h0, c[2:0], 1'b0, 1'b1));
         apb(1'b0, 12'h00C, 32'h0);
         chk(q <= ex && q + 16 >= ex, "settle count");
         wait_sv();
         t0 = t1;
         wait_sv();
         chk(t1 - t0 === (128 << c) * 2, "sample period");
      end
      $display("test rates done");
   endtask : t_rates

   task automatic t_reset2;
      @(posedge clock_i);
      reset_n_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      reset_n_i <= 1'b1;
      @(posedge clock_i);
      chk(s3act === 1'b0 && settled === 1'b0, "reset keeps sinc3");
      apb(1'b0, 12'h000, 32'h0);
      chk(q === 32'h0000_000C, "ctrl after second reset");
      apb(1'b1, 12'h000, ctrl(2'h0, 3'h0, 1'b1, 1'b1));
      wait_sv();
      chk(q === 32'h8000_0000 && s3act === 1'b0, "fast path after second reset");
      $display("test second reset done");
   endtask : t_reset2

   initial begin
      repeat (5) @(posedge clock_i);
      reset_n_i <= 1'b1;
      t_reset();
      t_div();
      t_fast();
      t_restart();
      t_rates();
      t_reset2();
      end_sim();
   end
endmodule : testbench
